// file: rtl/fij_map.vh
// Opcode, field and constant definitions for the execute block
`ifndef FIJ_MAP_VH
`define FIJ_MAP_VH
`define OPC_FP_COPROC 6'h11
`define OPC_SPECIAL3 6'h1F
`define OPC_REGION_JUMP 6'h02
`define OPC_REGION_CALL 6'h03
`define OPC_SPECIAL 6'h00
`define OPC_REGIMM 6'h01
`define FN_FLOOR_W 6'h0F
`define FN_FIELD_MERGE 6'h04
`define FN_JALR 6'h09
`define FMT_SINGLE 5'h10
`define FMT_DOUBLE 5'h11
`define LINK_GPR 5'h1F
`define LINK_OFFSET 32'h0000_0008
`define INT_MAX 32'h7FFF_FFFF
`define INT_MIN_M1 32'h8000_0001
`define INT_ZERO 32'h0000_0000
`define RMODE_FLOOR 2'h3
`define REL_FIELD_MERGE 3'h2
`define REL_CTI_TRAP 3'h6
`define EXC_NONE 3'h0
`define EXC_RESERVED 3'h1
`define EXC_CP_UNUSABLE 3'h2
`define EXC_FP_INVALID 3'h3
`define EXC_FP_UNIMPL 3'h4
`endif

// file: rtl/fp_floor_word.v
// Floating-point value to 32-bit integer, rounding toward minus infinity
`include "fij_map.vh"
module fp_floor_word (
	input wire [63:0] src,
	input wire is_double,
	output reg [31:0] result,
	output reg invalid,
	output reg inexact,
	output reg unimpl,
	output reg is_nan
);
	reg sign;
	reg [10:0] exp;
	reg [52:0] mant;
	reg mant_nz;
	reg is_special;
	reg signed [12:0] shift;
	reg [116:0] wide;
	reg [63:0] ipart;
	reg frac_nz;
	reg [64:0] mag;
	// Unpack, shift the significand into integer and fraction halves
	always @* begin
		sign = is_double ? src[63] : src[31];
		exp = is_double ? src[62:52] : {3'h0, src[30:23]};
		mant_nz = is_double ? (src[51:0] != 52'h0) : (src[22:0] != 23'h0);
		is_special = is_double ? (exp == 11'h7FF) : (exp == 11'h0FF);
		// Denormals flush toward zero magnitude but still report inexact
		if (is_double)
			mant = {(exp != 11'h0), src[51:0]};
		else
			mant = {(exp != 11'h0), src[22:0], 29'h0};
		if (is_double)
			shift = $signed({2'b00, exp}) - 13'sd1075;
		else
			shift = $signed({2'b00, exp}) - 13'sd1075 + 13'sd896;
		ipart = 64'h0;
		frac_nz = 1'b0;
		wide = 117'h0;
		if (exp == 11'h0) begin
			frac_nz = mant_nz;
		end else if (shift >= 13'sd11) begin
			ipart = 64'hFFFF_FFFF_FFFF_FFFF;
		end else if (shift >= 13'sd0) begin
			ipart = {11'h0, mant} << shift[3:0];
		end else if (shift > -13'sd64) begin
			wide = {mant, 64'h0} >> (-shift);
			// Upper 53 bits hold the integer part after the right shift
			ipart = {11'h0, wide[116:64]};
			frac_nz = (wide[63:0] != 64'h0);
		end else begin
			frac_nz = 1'b1;
		end
		// Floor: negative values with a fraction move one further down
		mag = {1'b0, ipart} + {64'h0, (sign & frac_nz)};
		is_nan = is_special & mant_nz;
		invalid = is_special
			| (!sign & (mag > 65'h0_7FFF_FFFF))
			| (sign & (mag > 65'h0_8000_0000));
		inexact = frac_nz & !is_special;
		unimpl = 1'b0;
		// Default results when trapping is off
		if (!invalid)
			result = sign ? (32'h0 - mag[31:0]) : mag[31:0];
		else
			result = `INT_MAX;
	end
endmodule

// file: rtl/floor_insert_jump_exec.v
// Execute stage for floor-to-word, field merge and region jump/call
`include "fij_map.vh"
module floor_insert_jump_exec (
	input wire MCLK,
	input wire RST_N,
	input wire ISSUE,
	input wire [31:0] INSTR,
	input wire [31:0] PC,
	input wire [31:0] GPR_SRC,
	input wire [31:0] GPR_TGT,
	input wire [63:0] FPR_SRC,
	input wire CP1_USABLE,
	input wire INVALID_ENABLE,
	input wire NAN_ENCODING_SELECT,
	input wire [2:0] ARCH_RELEASE,
	input wire IS_CTI,
	output reg GPR_WE,
	output reg [4:0] GPR_WADDR,
	output reg [31:0] GPR_WDATA,
	output reg FPR_WE,
	output reg [4:0] FPR_WADDR,
	output reg [31:0] FPR_WDATA,
	output reg FLAG_INVALID,
	output reg FLAG_INEXACT,
	output reg FLAG_UNIMPL,
	output reg EXC_VALID,
	output reg [2:0] EXC_CODE,
	output reg PC_LOAD,
	output reg [31:0] PC_TARGET
);
	//////////////////////////////////////////////////////////////////////
	// Field split
	wire [5:0] opcode = INSTR[31:26];
	wire [4:0] fmt_field = INSTR[25:21];
	wire [4:0] target_gpr_field = INSTR[20:16];
	wire [4:0] source_fp_reg_field = INSTR[15:11];
	wire [4:0] dest_fp_field = INSTR[10:6];
	wire [4:0] msb = INSTR[15:11];
	wire [4:0] lsb = INSTR[10:6];
	wire [5:0] funct = INSTR[5:0];
	wire [25:0] instr_index = INSTR[25:0];
	// Delay-slot tracking
	reg slot_pending_q; // Next issued instruction sits in a delay slot
	reg [31:0] jump_target_q; // Target held until the slot has issued
	// Decode
	wire is_floor = (opcode == `OPC_FP_COPROC) && (funct == `FN_FLOOR_W);
	wire fmt_ok = (fmt_field == `FMT_SINGLE) || (fmt_field == `FMT_DOUBLE);
	wire is_merge = (opcode == `OPC_SPECIAL3) && (funct == `FN_FIELD_MERGE);
	wire is_jump = (opcode == `OPC_REGION_JUMP);
	wire is_call = (opcode == `OPC_REGION_CALL);
	// Converter
	wire [31:0] cvt_result;
	wire cvt_invalid;
	wire cvt_inexact;
	wire cvt_unimpl;
	wire cvt_nan;
	fp_floor_word u_cvt (
		.src(FPR_SRC),
		.is_double(fmt_field == `FMT_DOUBLE),
		.result(cvt_result),
		.invalid(cvt_invalid),
		.inexact(cvt_inexact),
		.unimpl(cvt_unimpl),
		.is_nan(cvt_nan)
	);
	// Field merge mask and result; lsb > msb gives an empty mask, so GPR_TGT passes unchanged
	reg [31:0] mask;
	reg [31:0] merged;
	integer i;
	always @* begin
		for (i = 0; i < 32; i = i + 1)
			mask[i] = (i >= lsb) && (i <= msb);
		merged = (GPR_TGT & ~mask) | ((GPR_SRC << lsb) & mask);
	end
	// Default result chosen by the NaN encoding select
	reg [31:0] def_result;
	always @* begin
		if (!NAN_ENCODING_SELECT)
			def_result = `INT_MAX;
		else if (cvt_nan)
			def_result = `INT_ZERO;
		else if (FPR_SRC[fmt_field == `FMT_DOUBLE ? 63 : 31])
			def_result = `INT_MIN_M1;
		else
			def_result = `INT_MAX;
	end
	// Region target: upper bits from the delay-slot address
	wire [31:0] slot_pc = PC + 32'h0000_0004;
	wire [31:0] region_target = {slot_pc[31:28], instr_index, 2'b00};
	//////////////////////////////////////////////////////////////////////
	// Issue-time outputs, all registered
	always @(posedge MCLK) begin
		if (!RST_N) begin
			GPR_WE <= 1'b0;
			GPR_WADDR <= 5'h0;
			GPR_WDATA <= 32'h0;
			FPR_WE <= 1'b0;
			FPR_WADDR <= 5'h0;
			FPR_WDATA <= 32'h0;
			FLAG_INVALID <= 1'b0;
			FLAG_INEXACT <= 1'b0;
			FLAG_UNIMPL <= 1'b0;
			EXC_VALID <= 1'b0;
			EXC_CODE <= `EXC_NONE;
			PC_LOAD <= 1'b0;
			PC_TARGET <= 32'h0;
			slot_pending_q <= 1'b0;
			jump_target_q <= 32'h0;
		end else begin
			// Pulses default low every cycle
			GPR_WE <= 1'b0;
			FPR_WE <= 1'b0;
			FLAG_INVALID <= 1'b0;
			FLAG_INEXACT <= 1'b0;
			FLAG_UNIMPL <= 1'b0;
			EXC_VALID <= 1'b0;
			PC_LOAD <= 1'b0;
			if (ISSUE) begin
				// Slot instruction issued; now hand over the target
				if (slot_pending_q) begin
					slot_pending_q <= 1'b0;
					PC_LOAD <= 1'b1;
					PC_TARGET <= jump_target_q;
				end
				if (slot_pending_q && IS_CTI
					&& ARCH_RELEASE >= `REL_CTI_TRAP) begin
					EXC_VALID <= 1'b1;
					EXC_CODE <= `EXC_RESERVED;
				end else if (is_floor) begin
					if (!CP1_USABLE) begin
						EXC_VALID <= 1'b1;
						EXC_CODE <= `EXC_CP_UNUSABLE;
					end else if (!fmt_ok) begin
						EXC_VALID <= 1'b1;
						EXC_CODE <= `EXC_RESERVED;
					end else begin
						FLAG_INVALID <= cvt_invalid;
						FLAG_INEXACT <= cvt_inexact & !cvt_invalid;
						FLAG_UNIMPL <= cvt_unimpl;
						FPR_WADDR <= dest_fp_field;
						if (cvt_invalid && INVALID_ENABLE) begin
							EXC_VALID <= 1'b1;
							EXC_CODE <= `EXC_FP_INVALID;
						end else begin
							FPR_WE <= 1'b1;
							FPR_WDATA <= cvt_invalid ? def_result
								: cvt_result;
						end
					end
				end else if (is_merge) begin
					if (ARCH_RELEASE < `REL_FIELD_MERGE) begin
						EXC_VALID <= 1'b1;
						EXC_CODE <= `EXC_RESERVED;
					end else begin
						GPR_WE <= 1'b1;
						GPR_WADDR <= target_gpr_field;
						GPR_WDATA <= merged;
					end
				end else if (is_jump || is_call) begin
					// Target waits for the delay slot to issue
					slot_pending_q <= 1'b1;
					jump_target_q <= region_target;
					if (is_call) begin
						GPR_WE <= 1'b1;
						GPR_WADDR <= `LINK_GPR;
						GPR_WDATA <= PC + `LINK_OFFSET;
					end
				end
			end
		end
	end
endmodule

// file: verif/floor_insert_jump_exec_monitor.sv
// Port checker for the execute block
module floor_insert_jump_exec_monitor (
	input wire MCLK, input wire RST_N, input wire ISSUE,
	input wire [31:0] INSTR, input wire [31:0] PC,
	input wire CP1_USABLE, input wire INVALID_ENABLE,
	input wire [2:0] ARCH_RELEASE, input wire IS_CTI,
	input wire GPR_WE, input wire [4:0] GPR_WADDR,
	input wire [31:0] GPR_WDATA, input wire FPR_WE, input wire FLAG_INVALID,
	input wire EXC_VALID, input wire [2:0] EXC_CODE,
	input wire PC_LOAD, input wire [31:0] PC_TARGET
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Decoded issue kinds
	wire jmp = ISSUE && INSTR[31:27] == 5'h01;
	wire flr = ISSUE && INSTR[31:26] == 6'h11 && INSTR[5:0] == 6'h0F;
	wire fok = INSTR[25:21] == 5'h10 || INSTR[25:21] == 5'h11;
	wire mrg = ISSUE && INSTR[31:26] == 6'h1F && INSTR[5:0] == 6'h04;
	// Jump followed at once by its slot
	sequence s_slot;
		jmp ##1 ISSUE;
	endsequence
	a_call_link: assert property (ISSUE && INSTR[31:26] == 6'h03
		|=> GPR_WE && GPR_WADDR == 5'h1F
		&& GPR_WDATA == $past(PC) + 32'h8) else $error("link");
	a_slot_target: assert property (s_slot |=> PC_LOAD
		&& PC_TARGET == {$past(PC[31:28]), $past(INSTR[25:0], 2), 2'h0})
		else $error("target");
	a_cti_slot: assert property (jmp ##1 (ISSUE && IS_CTI
		&& ARCH_RELEASE >= 3'h6) |=> EXC_VALID && EXC_CODE == 3'h1)
		else $error("cti");
	a_cp_unusable: assert property (flr && fok && !CP1_USABLE
		|=> EXC_VALID && EXC_CODE == 3'h2 && !FPR_WE) else $error("cpu");
	a_fmt_reserved: assert property (flr && !fok && CP1_USABLE
		|=> EXC_VALID && EXC_CODE == 3'h1 && !FPR_WE) else $error("fmt");
	a_merge_old: assert property (mrg && ARCH_RELEASE < 3'h2
		|=> EXC_VALID && EXC_CODE == 3'h1 && !GPR_WE) else $error("rel");
	a_invalid_trap: assert property (FLAG_INVALID
		&& $past(INVALID_ENABLE) |-> EXC_VALID && EXC_CODE == 3'h3 && !FPR_WE)
		else $error("trap");
	a_invalid_dflt: assert property (FLAG_INVALID
		&& !$past(INVALID_ENABLE) |-> FPR_WE && !EXC_VALID) else $error("dflt");
endmodule
bind floor_insert_jump_exec floor_insert_jump_exec_monitor mon_u (.*);

// file: verif/test_floor_insert_jump_exec.sv
// Self-checking bench for the execute block
`include "fij_map.vh"
module test_floor_insert_jump_exec;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK = 1'b0, RST_N = 1'b0, ISSUE = 1'b0, IS_CTI = 1'b0;
	logic CP1_USABLE = 1'b1, INVALID_ENABLE = 1'b0, NAN_ENCODING_SELECT = 1'b0;
	logic [2:0] ARCH_RELEASE = 3'h6;
	logic [31:0] INSTR = 32'h0, PC = 32'h0, GPR_SRC = 32'h0, GPR_TGT = 32'h0;
	logic [63:0] FPR_SRC = 64'h0;
	wire GPR_WE, FPR_WE, FLAG_INVALID, FLAG_INEXACT, FLAG_UNIMPL;
	wire EXC_VALID, PC_LOAD;
	wire [4:0] GPR_WADDR, FPR_WADDR;
	wire [31:0] GPR_WDATA, FPR_WDATA, PC_TARGET;
	wire [2:0] EXC_CODE;
	int n_errors = 0, num_checks = 0;
	`define CHK(n, e, g) chk(n, e, g)
	floor_insert_jump_exec dut_u (.*);
	initial forever #10 MCLK = ~MCLK;
	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task end_of_test;
		$display("errors %0d, checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// One issue cycle; outputs are settled when this returns
	task op(input logic [31:0] i, input logic [31:0] p);
		INSTR = i;
		PC = p;
		ISSUE = 1'b1;
		@(negedge MCLK);
	endtask
	task exc_is(input logic [2:0] c);
		`CHK("exc", {1'b1, c}, {EXC_VALID, EXC_CODE});
	endtask
	// Floor model: {invalid, inexact, word}; NaN tested before compares
	function automatic logic [33:0] flr(input logic [63:0] v, input logic ns);
		real f;
		f = $floor($bitstoreal(v));
		if (v[62:52] == 11'h7FF && v[51:0] != 52'h0)
			return {2'h2, ns ? 32'h0 : `INT_MAX};
		if (f > 2147483647.0 || f < -2147483648.0)
			return {2'h2, (ns && v[63]) ? `INT_MIN_M1 : `INT_MAX};
		return {1'b0, f != $bitstoreal(v), 32'($rtoi(f))};
	endfunction
	task floor_case(input logic [63:0] v, input logic ns, input logic te);
		logic [33:0] e;
		e = flr(v, ns);
		NAN_ENCODING_SELECT = ns;
		INVALID_ENABLE = te;
		FPR_SRC = v;
		op({6'h11, 5'h11, 5'h00, 5'h03, 5'h07, 6'h0F}, 32'h0);
		`CHK("invalid", e[33], FLAG_INVALID);
		`CHK("fpr_we", !(te && e[33]), FPR_WE);
		`CHK("inexact", e[32], FLAG_INEXACT);
		`CHK("unimpl", 1'b0, FLAG_UNIMPL);
		if (!te)
			`CHK("fpr", {5'h07, e[31:0]}, {FPR_WADDR, FPR_WDATA});
	endtask
	// Field merge of lsb..msb; mask built in 64 bits so size 32 fits
	task merge_case(input logic [4:0] l, input logic [4:0] m);
		logic [63:0] k;
		GPR_SRC = $urandom;
		GPR_TGT = $urandom;
		k = ((64'h1 << (int'(m) - l + 1)) - 64'h1) << l;
		op({6'h1F, 5'h04, 5'h09, m, l, 6'h04}, 32'h0);
		k = (GPR_TGT & ~k) | ((GPR_SRC << l) & k);
		`CHK("merge", {1'b1, 5'h09, k[31:0]}, {GPR_WE, GPR_WADDR, GPR_WDATA});
	endtask
	// Jump or call, then a full-width merge in its slot
	task jump_case(input logic c, input logic [31:0] p, input logic [25:0] x);
		op({5'h01, c, x}, p);
		`CHK("link_we", c, GPR_WE);
		if (c)
			`CHK("link", {5'h1F, p + 32'h8}, {GPR_WADDR, GPR_WDATA});
		op(32'h7C89_F804, p + 32'h4);
		`CHK("slot", {1'b1, GPR_SRC}, {GPR_WE, GPR_WDATA});
		`CHK("pc_load", 1'b1, PC_LOAD);
		`CHK("target", {p[31:28] + (p[27:2] == 26'h3FF_FFFF), x, 2'h0}, PC_TARGET);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(97631));
		repeat (4) @(negedge MCLK);
		`CHK("reset", 4'h0, {GPR_WE, FPR_WE, EXC_VALID, PC_LOAD});
		RST_N = 1'b1;
		for (int n = 0; n < 2; n++) begin
			floor_case(64'h7FF8_0000_0000_0000, n, 1'b0);
			floor_case(64'hFFF0_0000_0000_0000, n, 1'b0);
			floor_case(64'hC1E0_0000_0010_0000, n, 1'b0);
			floor_case(64'h41E0_0000_0000_0000, n, 1'b0);
			floor_case(64'hC1E0_0000_0000_0000, n, 1'b0);
			floor_case(64'h41DF_FFFF_FFE0_0000, n, 1'b0);
		end
		floor_case(64'h7FF0_0000_0000_0000, 1'b0, 1'b1);
		exc_is(3'h3);
		repeat (40)
			floor_case($realtobits($itor($signed($urandom)) * 1.5), $urandom, 1'b0);
		FPR_SRC = 64'h0000_0000_BFC0_0000;
		op({6'h11, 5'h10, 10'h0, 5'h07, 6'h0F}, 32'h0);
		`CHK("single", 32'hFFFF_FFFE, FPR_WDATA);
		op({6'h11, 5'h14, 10'h0, 5'h07, 6'h0F}, 32'h0);
		exc_is(3'h1);
		CP1_USABLE = 1'b0;
		op({6'h11, 5'h11, 10'h0, 5'h07, 6'h0F}, 32'h0);
		exc_is(3'h2);
		CP1_USABLE = 1'b1;
		ARCH_RELEASE = 3'h1;
		op(32'h7C89_F804, 32'h0);
		exc_is(3'h1);
		ARCH_RELEASE = 3'h6;
		merge_case(5'h00, 5'h1F);
		merge_case(5'h1F, 5'h1F);
		repeat (30) begin
			PC = $urandom % 32;
			// Position and size kept legal by the stimulus
			merge_case(PC[4:0], PC[4:0] + $urandom % (32 - PC[4:0]));
		end
		jump_case(1'b0, 32'h1FFF_FFFC, $urandom);
		jump_case(1'b1, 32'h1FFF_FFFC, $urandom);
		repeat (10)
			jump_case($urandom, $urandom & 32'hFFFF_FFF8, $urandom);
		op(32'h0800_0040, 32'h0000_0100);
		IS_CTI = 1'b1;
		op(32'h0000_F809, 32'h0000_0104);
		exc_is(3'h1);
		end_of_test;
	end
	initial begin
		repeat (100000) @(posedge MCLK);
		n_errors++;
		end_of_test;
	end
endmodule
